/* File: core/lpic_defs.vh */
// constants for the low-power interrupt and special function register controller
`ifndef LPIC_DEFS_VH
`define LPIC_DEFS_VH
`define LPIC_OFS_IE1        8'h00
`define LPIC_OFS_IE2        8'h01
`define LPIC_OFS_IFG1       8'h02
`define LPIC_OFS_IFG2       8'h03
`define LPIC_OFS_ME1        8'h04
`define LPIC_OFS_ME2        8'h05
// status word bit positions
`define LPIC_SR_C           0
`define LPIC_SR_Z           1
`define LPIC_SR_N           2
`define LPIC_SR_GIE         3
`define LPIC_SR_PROCESSOR_HALT_BIT      4
`define LPIC_SR_CRYSTAL_STOP_BIT      5
`define LPIC_SR_CLOCK_GEN_OFF_LO        6
`define LPIC_SR_CLOCK_GEN_OFF_HI        7
`define LPIC_SR_V           8
`define LPIC_SR_IMPL_MASK   16'h01FF
`define LPIC_SR_RESET       16'h0000
// first enable / flag register bits
`define LPIC_B1_WDT         0
`define LPIC_B1_OFS         1
`define LPIC_B1_P0          2
`define LPIC_B1_P1          3
`define LPIC_B1_NMI         4
`define LPIC_IE1_MASK       8'h0F
`define LPIC_IFG1_MASK      8'h1F
// second enable / flag register bits
`define LPIC_B2_TP          0
`define LPIC_B2_BT          1
`define LPIC_IE2_MASK       8'h03
`define LPIC_IFG2_MASK      8'h02
// module enable registers: two implemented bits each
`define LPIC_ME_MASK        8'h03
`define LPIC_ME_RESET       8'h00
// vector word addresses
`define LPIC_VEC_RESET      16'hFFFE
`define LPIC_VEC_NMI        16'hFFFC
`define LPIC_VEC_P0         16'hFFFA
`define LPIC_VEC_P1         16'hFFF8
`define LPIC_VEC_WDT        16'hFFF4
`define LPIC_VEC_TP         16'hFFEA
`define LPIC_VEC_BT         16'hFFE2
`define LPIC_VEC_PORT       16'hFFE0
`define LPIC_VEC_BASE       16'hFFE0
`endif

/* File: core/lpic_ctrl.v */
// low-power mode, interrupt arbitration and special function registers
// Operation
// - any enabled event wakes; return restores mode
// - cpu halted in every sleep level
// - level a: both clocks, loop running
// - level b: both clocks, loop halted
// - level c: auxiliary clock only
// - level d: also oscillator bias off
// - level e: crystal stopped, everything off
// - status word layout, reserved high, reset zero
// - four status bits select operating mode
// - vectors in top 32 bytes
// - priority follows vector address
// - timer/port request is multi-source, flags outside
// - first enable register at 0h
// - second enable register at 01h
// - watchdog flag set/clear conditions
// - flag register holds fault, pin, port flags
// - second flag register holds base timer flag
// - module enable registers at 04h, 05h
// - peripheral access independent of module enable
// - resettable bits clear on power-up clear
// - unassigned bit positions not implemented
// - crystal runs after reset, stop bit stops it
// - only two port lines in flag area
`include "lpic_defs.vh"
`default_nettype none
module lpic_ctrl (
    input  wire        clk_in,
    input  wire        reset_in,
    input  wire        por_in,
    input  wire        pin_reset_in,
    input  wire        wdt_reset_in,
    input  wire        sfr_wr_in,
    input  wire        sfr_rd_in,
    input  wire [7:0]  sfr_addr_in,
    input  wire [7:0]  sfr_wdata_in,
    input  wire        sr_wr_in,
    input  wire [15:0] sr_wdata_in,
    input  wire        irq_ack_in,
    input  wire        return_from_irq_in,
    input  wire [15:0] return_from_irq_sr_in,
    input  wire        wdt_event_in,
    input  wire        osc_fault_in,
    input  wire        nmi_pin_in,
    input  wire        port0_event_in,
    input  wire        port1_event_in,
    input  wire        port_upper_req_in,
    input  wire        timer_port_req_in,
    input  wire        base_timer_event_in,
    output reg  [7:0]  sfr_rdata_out,
    output reg  [15:0] sr_out,
    output reg         irq_req_out,
    output reg  [15:0] irq_vector_out,
    output reg         cpu_run_out,
    output reg         aclk_en_out,
    output reg         mclk_en_out,
    output reg         fll_en_out,
    output reg         dco_bias_en_out,
    output reg         xtal_en_out,
    output reg  [2:0]  op_mode_out,
    output reg  [7:0]  module_enable1_out,
    output reg  [7:0]  module_enable2_out
);
////////////////////////////////////////////////////////////////////////////////
localparam MODE_ACTIVE = 3'd0;
localparam MODE_A      = 3'd1;
localparam MODE_B      = 3'd2;
localparam MODE_C      = 3'd3;
localparam MODE_D      = 3'd4;
localparam MODE_E      = 3'd5;
// nmi pin, oscillator fault and port1 pass two flops before any logic sees them
reg  [2:0]  sync1_q;
reg  [2:0]  sync2_q;
reg  [2:0]  sync_prev_q;
wire [2:0]  sync_rise;
reg  [15:0] sr_q;
reg  [15:0] sr_d;
reg  [7:0]  ie1_q;
reg  [7:0]  ie2_q;
reg  [7:0]  ifg1_q;
reg  [7:0]  ifg1_d;
reg  [7:0]  ifg2_q;
reg  [7:0]  ifg2_d;
reg  [7:0]  me1_q;
reg  [7:0]  me2_q;
reg         grant_v;
reg  [15:0] vec_v;
reg  [2:0]  mode_v;
wire        global_irq_enable;
wire        hw_reset;
wire        wr_ie1;
wire        wr_ie2;
wire        wr_ifg1;
wire        wr_ifg2;
wire        wr_me1;
wire        wr_me2;
////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
        sync1_q     <= 3'h0;
        sync2_q     <= 3'h0;
        sync_prev_q <= 3'h0;
    end else begin
        sync1_q     <= {nmi_pin_in, osc_fault_in, port1_event_in};
        sync2_q     <= sync1_q;
        sync_prev_q <= sync2_q;
    end
end
assign sync_rise = sync2_q & ~sync_prev_q;
assign global_irq_enable       = sr_q[`LPIC_SR_GIE];
// power-up clear covers supply, pin and watchdog resets
assign hw_reset  = por_in | pin_reset_in | wdt_reset_in;
assign wr_ie1    = sfr_wr_in && (sfr_addr_in == `LPIC_OFS_IE1);
assign wr_ie2    = sfr_wr_in && (sfr_addr_in == `LPIC_OFS_IE2);
assign wr_ifg1   = sfr_wr_in && (sfr_addr_in == `LPIC_OFS_IFG1);
assign wr_ifg2   = sfr_wr_in && (sfr_addr_in == `LPIC_OFS_IFG2);
assign wr_me1    = sfr_wr_in && (sfr_addr_in == `LPIC_OFS_ME1);
assign wr_me2    = sfr_wr_in && (sfr_addr_in == `LPIC_OFS_ME2);
////////////////////////////////////////////////////////////////////////////////
// arbitration: highest vector address wins
always @* begin
    grant_v = 1'b0;
    vec_v   = `LPIC_VEC_BASE;
    if (ifg1_q[`LPIC_B1_NMI] || (ifg1_q[`LPIC_B1_OFS] && ie1_q[`LPIC_B1_OFS])) begin
        grant_v = 1'b1;
        vec_v   = `LPIC_VEC_NMI;
    end else if (global_irq_enable) begin
        if (ifg1_q[`LPIC_B1_P0] && ie1_q[`LPIC_B1_P0]) begin
            grant_v = 1'b1;
            vec_v   = `LPIC_VEC_P0;
        end else if (ifg1_q[`LPIC_B1_P1] && ie1_q[`LPIC_B1_P1]) begin
            grant_v = 1'b1;
            vec_v   = `LPIC_VEC_P1;
        end else if (ifg1_q[`LPIC_B1_WDT] && ie1_q[`LPIC_B1_WDT]) begin
            grant_v = 1'b1;
            vec_v   = `LPIC_VEC_WDT;
        end else if (timer_port_req_in && ie2_q[`LPIC_B2_TP]) begin
            grant_v = 1'b1;
            vec_v   = `LPIC_VEC_TP;
        end else if (ifg2_q[`LPIC_B2_BT] && ie2_q[`LPIC_B2_BT]) begin
            grant_v = 1'b1;
            vec_v   = `LPIC_VEC_BT;
        end else if (port_upper_req_in) begin
            grant_v = 1'b1;
            vec_v   = `LPIC_VEC_PORT;
        end
    end
end
////////////////////////////////////////////////////////////////////////////////
// flag next values: hardware set wins over software write
always @* begin
    ifg1_d = ifg1_q;
    ifg2_d = ifg2_q;
    if (wr_ifg1)
        ifg1_d = sfr_wdata_in & `LPIC_IFG1_MASK;
    if (wr_ifg2)
        ifg2_d = sfr_wdata_in & `LPIC_IFG2_MASK;
    // nmi and port0 flags auto-clear when serviced, others stay for software
    if (irq_ack_in && grant_v && vec_v == `LPIC_VEC_NMI)
        ifg1_d[`LPIC_B1_NMI] = 1'b0;
    if (irq_ack_in && grant_v && vec_v == `LPIC_VEC_P0)
        ifg1_d[`LPIC_B1_P0] = 1'b0;
    if (wdt_event_in)
        ifg1_d[`LPIC_B1_WDT] = 1'b1;
    if (sync_rise[1])
        ifg1_d[`LPIC_B1_OFS] = 1'b1;
    if (sync_rise[2])
        ifg1_d[`LPIC_B1_NMI] = 1'b1;
    if (port0_event_in)
        ifg1_d[`LPIC_B1_P0] = 1'b1;
    if (sync_rise[0])
        ifg1_d[`LPIC_B1_P1] = 1'b1;
    if (base_timer_event_in)
        ifg2_d[`LPIC_B2_BT] = 1'b1;
end
////////////////////////////////////////////////////////////////////////////////
// status word: software write, entry on grant, restore on return
always @* begin
    sr_d = sr_q;
    if (sr_wr_in)
        sr_d = sr_wdata_in & `LPIC_SR_IMPL_MASK;
    if (return_from_irq_in)
        sr_d = return_from_irq_sr_in & `LPIC_SR_IMPL_MASK;
    if (irq_ack_in && grant_v) begin
        // handler runs active; old word is stacked by the cpu
        sr_d[`LPIC_SR_GIE]    = 1'b0;
        sr_d[`LPIC_SR_PROCESSOR_HALT_BIT] = 1'b0;
        sr_d[`LPIC_SR_CRYSTAL_STOP_BIT] = 1'b0;
        sr_d[`LPIC_SR_CLOCK_GEN_OFF_LO]   = 1'b0;
        sr_d[`LPIC_SR_CLOCK_GEN_OFF_HI]   = 1'b0;
    end
end
////////////////////////////////////////////////////////////////////////////////
always @* begin
    mode_v = MODE_ACTIVE;
    if (sr_q[`LPIC_SR_PROCESSOR_HALT_BIT]) begin
        case ({sr_q[`LPIC_SR_CLOCK_GEN_OFF_HI], sr_q[`LPIC_SR_CLOCK_GEN_OFF_LO], sr_q[`LPIC_SR_CRYSTAL_STOP_BIT]})
            3'b000:  mode_v = MODE_A;
            3'b010:  mode_v = MODE_B;
            3'b100:  mode_v = MODE_C;
            3'b110:  mode_v = MODE_D;
            default: mode_v = MODE_E;
        endcase
    end else if (sr_q[`LPIC_SR_CRYSTAL_STOP_BIT]) begin
        mode_v = MODE_E;
    end
end
////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
        sr_q   <= `LPIC_SR_RESET;
        ie1_q  <= 8'h00;
        ie2_q  <= 8'h00;
        ifg1_q <= 8'h00;
        ifg2_q <= 8'h00;
        me1_q  <= `LPIC_ME_RESET;
        me2_q  <= `LPIC_ME_RESET;
    end else if (hw_reset) begin
        sr_q   <= `LPIC_SR_RESET;
        ie1_q  <= 8'h00;
        ie2_q  <= 8'h00;
        me1_q  <= `LPIC_ME_RESET;
        me2_q  <= `LPIC_ME_RESET;
        ifg2_q <= ifg2_d;
        // watchdog reset leaves its own flag set, supply or pin reset clears it
        ifg1_q <= {ifg1_d[7:1], wdt_reset_in & ~por_in & ~pin_reset_in};
    end else begin
        sr_q   <= sr_d;
        ifg1_q <= ifg1_d;
        ifg2_q <= ifg2_d;
        if (wr_ie1)
            ie1_q <= sfr_wdata_in & `LPIC_IE1_MASK;
        if (wr_ie2)
            ie2_q <= sfr_wdata_in & `LPIC_IE2_MASK;
        if (wr_me1)
            me1_q <= sfr_wdata_in & `LPIC_ME_MASK;
        if (wr_me2)
            me2_q <= sfr_wdata_in & `LPIC_ME_MASK;
    end
end
////////////////////////////////////////////////////////////////////////////////
// registered outputs
always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
        sfr_rdata_out      <= 8'h00;
        sr_out             <= 16'h0000;
        irq_req_out        <= 1'b0;
        irq_vector_out     <= `LPIC_VEC_RESET;
        cpu_run_out        <= 1'b0;
        aclk_en_out        <= 1'b0;
        mclk_en_out        <= 1'b0;
        fll_en_out         <= 1'b0;
        dco_bias_en_out    <= 1'b0;
        xtal_en_out        <= 1'b0;
        op_mode_out        <= MODE_ACTIVE;
        module_enable1_out <= 8'h00;
        module_enable2_out <= 8'h00;
    end else begin
        sfr_rdata_out <= 8'h00;
        if (sfr_rd_in) begin
            case (sfr_addr_in)
                `LPIC_OFS_IE1:  sfr_rdata_out <= ie1_q;
                `LPIC_OFS_IE2:  sfr_rdata_out <= ie2_q;
                `LPIC_OFS_IFG1: sfr_rdata_out <= ifg1_q;
                `LPIC_OFS_IFG2: sfr_rdata_out <= ifg2_q;
                `LPIC_OFS_ME1:  sfr_rdata_out <= me1_q;
                `LPIC_OFS_ME2:  sfr_rdata_out <= me2_q;
                default:        sfr_rdata_out <= 8'h00;
            endcase
        end
        sr_out         <= sr_q;
        irq_req_out    <= grant_v;
        irq_vector_out <= hw_reset ? `LPIC_VEC_RESET : vec_v;
        op_mode_out    <= mode_v;
        // a pending grant wakes the cpu even before the status word changes
        // the stop bit alone also halts: the system clock is gone in that level
        cpu_run_out    <= (mode_v == MODE_ACTIVE) | grant_v;
        case (mode_v)
            MODE_ACTIVE, MODE_A: begin
                aclk_en_out <= 1'b1;
                mclk_en_out <= 1'b1;
                fll_en_out  <= 1'b1;
                dco_bias_en_out <= 1'b1;
                xtal_en_out <= 1'b1;
            end
            MODE_B: begin
                aclk_en_out <= 1'b1;
                mclk_en_out <= 1'b1;
                fll_en_out  <= 1'b0;
                dco_bias_en_out <= 1'b1;
                xtal_en_out <= 1'b1;
            end
            MODE_C: begin
                aclk_en_out <= 1'b1;
                mclk_en_out <= 1'b0;
                fll_en_out  <= 1'b0;
                dco_bias_en_out <= 1'b1;
                xtal_en_out <= 1'b1;
            end
            MODE_D: begin
                aclk_en_out <= 1'b1;
                mclk_en_out <= 1'b0;
                fll_en_out  <= 1'b0;
                dco_bias_en_out <= 1'b0;
                xtal_en_out <= 1'b1;
            end
            default: begin
                aclk_en_out <= 1'b0;
                mclk_en_out <= 1'b0;
                fll_en_out  <= 1'b0;
                dco_bias_en_out <= 1'b0;
                xtal_en_out <= 1'b0;
            end
        endcase
        // enables gate the peripheral only; its registers stay accessible
        module_enable1_out <= me1_q;
        module_enable2_out <= me2_q;
    end
end
endmodule
`default_nettype wire

/* File: test/lpic_checker.sv */
// port-level assertions for the low-power interrupt controller
`default_nettype none
module lpic_checker (
    input wire logic        clk_in,
    input wire logic        reset_in,
    input wire logic        por_in,
    input wire logic        pin_reset_in,
    input wire logic        wdt_reset_in,
    input wire logic        sfr_rd_in,
    input wire logic        sr_wr_in,
    input wire logic [15:0] sr_wdata_in,
    input wire logic        irq_ack_in,
    input wire logic        return_from_irq_in,
    input wire logic [15:0] return_from_irq_sr_in,
    input wire logic [7:0]  sfr_rdata_out,
    input wire logic [15:0] sr_out,
    input wire logic        irq_req_out,
    input wire logic        cpu_run_out,
    input wire logic        aclk_en_out,
    input wire logic        mclk_en_out,
    input wire logic        fll_en_out,
    input wire logic        dco_bias_en_out,
    input wire logic        xtal_en_out,
    input wire logic [2:0]  op_mode_out,
    input wire logic [7:0]  module_enable1_out
);
    timeunit 1ns;
    timeprecision 1ns;
    wire pwr_clear = por_in | pin_reset_in | wdt_reset_in;
    // stop bit forces the deepest level whether or not the cpu is halted
    function automatic logic [2:0] mode_of(input logic [15:0] s);
        return s[5] ? 3'h5 : (s[4] ? 3'h1 + {1'b0, s[7:6]} : 3'h0);
    endfunction
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    ////////////////////////////////////////////////////////////////////////////
    chk_sr_write: assert property (sr_wr_in && !return_from_irq_in && !irq_ack_in && !pwr_clear
        |-> ##2 sr_out == ($past(sr_wdata_in, 2) & 16'h01FF)) else $error("status word write lost");
    chk_return_from_irq_restore: assert property (return_from_irq_in && !irq_ack_in && !pwr_clear
        |-> ##2 sr_out == ($past(return_from_irq_sr_in, 2) & 16'h01FF)) else $error("return did not restore status");
    chk_ack_wakes: assert property (irq_ack_in && irq_req_out
        |-> ##2 sr_out[5:3] == 3'h0 && sr_out[7:6] == 2'h0) else $error("grant left sleep bits set");
    chk_mode_decode: assert property (sr_out == $past(sr_out) && sr_out == $past(sr_out, 2)
        |-> op_mode_out == mode_of(sr_out)) else $error("operating mode does not follow status");
    chk_cpu_halt: assert property (op_mode_out != 3'h0 && !irq_req_out |-> !cpu_run_out)
        else $error("cpu runs while asleep");
    chk_grant_wakes: assert property (irq_req_out |-> cpu_run_out)
        else $error("cpu left halted with a grant pending");
    chk_level_a: assert property (op_mode_out == 3'h1 |-> aclk_en_out && mclk_en_out && fll_en_out)
        else $error("level a clocks wrong");
    chk_level_b: assert property (op_mode_out == 3'h2 |-> aclk_en_out && mclk_en_out && !fll_en_out)
        else $error("level b clocks wrong");
    chk_level_c: assert property (op_mode_out == 3'h3 |-> aclk_en_out && !mclk_en_out && !fll_en_out)
        else $error("level c clocks wrong");
    chk_level_d: assert property (op_mode_out == 3'h4
        |-> aclk_en_out && !mclk_en_out && !fll_en_out && !dco_bias_en_out) else $error("level d clocks wrong");
    chk_level_e: assert property (op_mode_out == 3'h5 |-> !aclk_en_out && !mclk_en_out
        && !fll_en_out && !dco_bias_en_out && !xtal_en_out) else $error("level e clocks wrong");
    chk_rdata_idle: assert property (!sfr_rd_in |=> sfr_rdata_out == 8'h00)
        else $error("read data outside a read");
    chk_pwr_clear: assert property (pwr_clear |-> ##2 sr_out == 16'h0000 && module_enable1_out == 8'h00)
        else $error("power-up clear missed a register");
endmodule
bind lpic_ctrl lpic_checker u_lpic_checker (.clk_in, .reset_in, .por_in, .pin_reset_in, .wdt_reset_in,
    .sfr_rd_in, .sr_wr_in, .sr_wdata_in, .irq_ack_in, .return_from_irq_in, .return_from_irq_sr_in, .sfr_rdata_out, .sr_out,
    .irq_req_out, .cpu_run_out, .aclk_en_out, .mclk_en_out, .fll_en_out, .dco_bias_en_out, .xtal_en_out,
    .op_mode_out, .module_enable1_out);
`default_nettype wire

/* File: test/lpic_periph.sv */
// peripheral interrupt sources in front of the controller
`default_nettype none
module lpic_periph (
    input  wire logic clk_in,
    output logic      wdt_event_out,
    output logic      port0_event_out,
    output logic      base_timer_event_out,
    output logic      nmi_pin_out,
    output logic      osc_fault_out,
    output logic      port1_event_out,
    output logic      timer_port_req_out,
    output logic      port_upper_req_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {wdt_event_out, port0_event_out, base_timer_event_out, nmi_pin_out} = 4'h0;
    initial {osc_fault_out, port1_event_out, timer_port_req_out, port_upper_req_out} = 4'h0;
    // pulses last one cycle, async levels four so the 2-flop sync sees them
    task automatic fire(input logic [5:0] sel);
        @(negedge clk_in);
        {osc_fault_out, nmi_pin_out, port1_event_out} = sel[5:3];
        {base_timer_event_out, port0_event_out, wdt_event_out} = sel[2:0];
        @(negedge clk_in);
        {base_timer_event_out, port0_event_out, wdt_event_out} = 3'h0;
        repeat (3) @(negedge clk_in);
        {osc_fault_out, nmi_pin_out, port1_event_out} = 3'h0;
    endtask
    // shared requests hold their level until the next call of level changes them
    task automatic level(input logic tp, input logic upper);
        @(negedge clk_in);
        timer_port_req_out = tp;
        port_upper_req_out = upper;
    endtask
endmodule
`default_nettype wire

/* File: test/lpic_ctrl_tb.sv */
// self-checking bench for the low-power interrupt controller
`default_nettype none
module lpic_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in, reset_in, por_in, pin_reset_in, wdt_reset_in, sfr_wr_in, sfr_rd_in;
    logic [7:0]  sfr_addr_in, sfr_wdata_in, sfr_rdata_out, module_enable1_out, module_enable2_out;
    logic        sr_wr_in, irq_ack_in, return_from_irq_in, irq_req_out, cpu_run_out, xtal_en_out, rd_take;
    logic [15:0] sr_wdata_in, return_from_irq_sr_in, sr_out, irq_vector_out, s;
    logic [2:0]  op_mode_out;
    logic        ev_wdt, ev_p0, ev_bt, lv_nmi, lv_osc, ev_p1, rq_tp, rq_up;
    logic [7:0]  exp_q[$];
    logic [7:0]  v;
    int          mismatches, n_compared;
    logic [7:0]  addrs [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
    logic [7:0]  masks [5] = '{8'h0F, 8'h03, 8'h03, 8'h03, 8'h00};
    logic [15:0] pats [6]  = '{16'h0000, 16'h0010, 16'h0050, 16'h0090, 16'h00D0, 16'h0030};
    lpic_ctrl u_lpic_ctrl (.clk_in, .reset_in, .por_in, .pin_reset_in, .wdt_reset_in, .sfr_wr_in,
        .sfr_rd_in, .sfr_addr_in, .sfr_wdata_in, .sr_wr_in, .sr_wdata_in, .irq_ack_in, .return_from_irq_in,
        .return_from_irq_sr_in, .wdt_event_in(ev_wdt), .osc_fault_in(lv_osc), .nmi_pin_in(lv_nmi),
        .port0_event_in(ev_p0), .port1_event_in(ev_p1), .port_upper_req_in(rq_up),
        .timer_port_req_in(rq_tp), .base_timer_event_in(ev_bt), .sfr_rdata_out, .sr_out, .irq_req_out,
        .irq_vector_out, .cpu_run_out, .aclk_en_out(), .mclk_en_out(), .fll_en_out(), .dco_bias_en_out(),
        .xtal_en_out, .op_mode_out, .module_enable1_out, .module_enable2_out);
    lpic_periph u_lpic_periph (.clk_in, .wdt_event_out(ev_wdt), .port0_event_out(ev_p0),
        .base_timer_event_out(ev_bt), .nmi_pin_out(lv_nmi), .osc_fault_out(lv_osc),
        .port1_event_out(ev_p1), .timer_port_req_out(rq_tp), .port_upper_req_out(rq_up));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic sfr_op(input logic rd, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        sfr_rd_in = rd;
        sfr_wr_in = !rd;
        sfr_addr_in = a;
        sfr_wdata_in = d;
        if (rd) exp_q.push_back(d);
        @(negedge clk_in);
        {sfr_rd_in, sfr_wr_in} = 2'b00;
    endtask
    task automatic sr_op(input logic ret, input logic [15:0] d);
        @(negedge clk_in);
        {sr_wr_in, return_from_irq_in} = {!ret, ret};
        {sr_wdata_in, return_from_irq_sr_in} = {d, d};
        @(negedge clk_in);
        {sr_wr_in, return_from_irq_in} = 2'b00;
    endtask
    task automatic pulse_reset(input logic [2:0] which);
        @(negedge clk_in);
        {por_in, pin_reset_in, wdt_reset_in} = which;
        @(negedge clk_in);
        {por_in, pin_reset_in, wdt_reset_in} = 3'h0;
        check(irq_vector_out, 16'hFFFE);
    endtask
    // waits for a grant, checks its vector, then takes it
    task automatic take_irq(input logic [15:0] e);
        for (int n = 0; n < 20 && irq_req_out !== 1'b1; n++) @(negedge clk_in);
        check(irq_vector_out, e);
        irq_ack_in = 1'b1;
        @(negedge clk_in);
        irq_ack_in = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    always @(posedge clk_in) rd_take <= sfr_rd_in;
    always @(negedge clk_in) begin
        if (rd_take === 1'b1) check({8'h00, sfr_rdata_out}, {8'h00, exp_q.pop_front()});
    end
    initial begin
        #250us;
        mismatches++;
        finish_test();
    end
    initial begin
        {reset_in, por_in, pin_reset_in, wdt_reset_in, sfr_wr_in, sfr_rd_in} = 6'h20;
        {sr_wr_in, irq_ack_in, return_from_irq_in, sfr_addr_in, sfr_wdata_in} = 19'h0;
        {sr_wdata_in, return_from_irq_sr_in} = 32'h0;
        {mismatches, n_compared} = 64'h0;
        v = 8'($urandom(32'h13CA322D));
        repeat (20) @(negedge clk_in);
        reset_in = 1'b0;
        for (int i = 0; i < 5; i++) begin
            sfr_op(1'b1, addrs[i], 8'h00);
            v = 8'($urandom);
            sfr_op(1'b0, addrs[i], v);
            sfr_op(1'b1, addrs[i], v & masks[i]);
        end
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            s = pats[i] | (16'($urandom) & 16'hFE07);
            sr_op(1'b0, s);
            repeat (3) @(negedge clk_in);
            check(sr_out, s & 16'h01FF);
            check({13'h0, op_mode_out}, 16'(i));
            check({15'h0, cpu_run_out}, {15'h0, i == 0});
        end
        $display("test modes done");
        sfr_op(1'b0, 8'h00, 8'h0F);
        sfr_op(1'b0, 8'h01, 8'h03);
        sr_op(1'b0, 16'h0098);
        u_lpic_periph.fire(6'h07);
        take_irq(16'hFFFA);
        repeat (3) @(negedge clk_in);
        check({12'h0, op_mode_out, cpu_run_out}, 16'h0001);
        sr_op(1'b1, 16'h0098);
        repeat (3) @(negedge clk_in);
        check({13'h0, op_mode_out}, 16'h0003);
        take_irq(16'hFFF4);
        sfr_op(1'b0, 8'h02, 8'h00);
        sr_op(1'b1, 16'h0098);
        take_irq(16'hFFE2);
        sfr_op(1'b0, 8'h03, 8'h00);
        u_lpic_periph.fire(6'h10);
        take_irq(16'hFFFC);
        u_lpic_periph.fire(6'h08);
        sr_op(1'b1, 16'h0008);
        take_irq(16'hFFF8);
        sfr_op(1'b0, 8'h02, 8'h00);
        u_lpic_periph.fire(6'h20);
        take_irq(16'hFFFC);
        sfr_op(1'b1, 8'h02, 8'h02);
        sfr_op(1'b0, 8'h02, 8'h00);
        u_lpic_periph.level(1'b1, 1'b1);
        sr_op(1'b1, 16'h0008);
        take_irq(16'hFFEA);
        u_lpic_periph.level(1'b0, 1'b1);
        sr_op(1'b1, 16'h0008);
        take_irq(16'hFFE0);
        u_lpic_periph.level(1'b0, 1'b0);
        $display("test interrupts done");
        sr_op(1'b0, 16'h0020);
        repeat (3) @(negedge clk_in);
        check({15'h0, xtal_en_out}, 16'h0000);
        check({15'h0, cpu_run_out}, 16'h0000);
        sfr_op(1'b0, 8'h05, 8'h03);
        sfr_op(1'b0, 8'h04, 8'h03);
        check({8'h00, module_enable2_out}, 16'h0003);
        pulse_reset(3'h1);
        sfr_op(1'b1, 8'h02, 8'h01);
        sfr_op(1'b1, 8'h04, 8'h00);
        check({8'h00, module_enable2_out}, 16'h0000);
        check({15'h0, xtal_en_out}, 16'h0001);
        pulse_reset(3'h2);
        sfr_op(1'b1, 8'h02, 8'h00);
        sr_op(1'b0, 16'h01F8);
        pulse_reset(3'h4);
        @(negedge clk_in);
        check(sr_out, 16'h0000);
        $display("test power-up clear done");
        finish_test();
    end
endmodule
`default_nettype wire
